// *** cpuctl_pkg.sv ***
// Constants for the processor control pin handling block.
// Assumes one 10 MHz bus clock and a classic Wishbone register slave.
// Summary of operation
// - On hold request finish outstanding cycles, float bus, then acknowledge.
// - Keep bus floated and acknowledge high while hold request stays asserted.
// - Do not grant hold during a locked sequence; grant after it ends.
// - Answer hold requests even while reset is asserted.
// - Internal array parity error pulses internal error one clock, then shutdown.
// - Checker mismatch asserts internal error two clocks after the value returned.
// - With native numeric error bit set, ignore numeric error input has no effect.
// - Native bit clear and ignore asserted: keep executing FP despite pending exception.
// - Native clear, ignore off, exception pending: non-waiting control instructions still run.
// - Under same conditions other FP instructions halt until an external interrupt.
// - Secondary processor of a dual pair masks ignore numeric error internally.
// - Warm init restarts like reset but caches, buffers, FP registers keep contents.
// - Warm init high when reset falls runs built-in self test before execution; the code holds off interrupts during the test, not fp_execute_o.
// - Irq with interrupt enable: finish instruction, two locked acknowledges, then vector.
// - With local interrupt controller enabled the irq pin is local interrupt 0.
// - Leaving hold drops acknowledge and drives any pending cycle in that clock.
// - Checker mode floats all outputs except internal error and test data out; the code only raises bus_float_o in checker mode.
`default_nettype none

package cpuctl_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_VECTOR = 4'h8;
  localparam int CTL_NATIVE = 0;
  localparam int CTL_IEN = 1;
  localparam int CTL_LAPIC = 2;
  localparam logic [2:0] CONTROL_RESET = 3'h0;
  localparam int ST_HOLD = 0;
  localparam int ST_SHUTDOWN = 1;
  localparam int ST_FP_HALT = 2;
  localparam int ST_BIST = 3;
  localparam int ST_CHECKER = 4;
  localparam int ST_IRQ_BUSY = 5;
  localparam int CHECK_DELAY = 2;
  localparam int INTERNAL_ERROR_OUT_PULSE = 1;
  localparam int BIST_CYCLES = 16;

  typedef enum logic [2:0] {
    HOLD_RUN = 3'b001,
    HOLD_DRAIN = 3'b010,
    HOLD_HELD = 3'b100
  } cpuctl_hold_type;

  typedef enum logic [4:0] {
    IRQ_IDLE = 5'b00001,
    IRQ_ACK1 = 5'b00010,
    IRQ_GAP = 5'b00100,
    IRQ_ACK2 = 5'b01000,
    IRQ_VEC = 5'b10000
  } cpuctl_irq_type;
endpackage : cpuctl_pkg

`default_nettype wire

// *** cpuctl_hold.sv ***
// Bus hold arbitration for the processor bus.
// Assumes busy and lock come from the bus cycle engine in the same clock.
`default_nettype none

module cpuctl_hold
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hold_req_i,
  input wire logic busy_i,
  input wire logic locked_i,
  input wire logic pending_i,
  output logic bus_hold_ack_o,
  output logic drive_pending_o
);
  cpuctl_pkg::cpuctl_hold_type state;
  cpuctl_pkg::cpuctl_hold_type next_state;
  logic drive_q;
  wire logic can_grant;

  // Locked sequences and open cycles both block the grant
  assign can_grant = !busy_i && !locked_i;

  always_comb
  begin
    next_state = state;
    case (state)
      cpuctl_pkg::HOLD_RUN:
        if (hold_req_i)
          next_state = can_grant ? cpuctl_pkg::HOLD_HELD : cpuctl_pkg::HOLD_DRAIN;
      cpuctl_pkg::HOLD_DRAIN:
        if (!hold_req_i)
          next_state = cpuctl_pkg::HOLD_RUN;
        else if (can_grant)
          next_state = cpuctl_pkg::HOLD_HELD;
      cpuctl_pkg::HOLD_HELD:
        if (!hold_req_i)
          next_state = cpuctl_pkg::HOLD_RUN;
      default:
        next_state = cpuctl_pkg::HOLD_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      // No cycles run in reset, so a hold is granted at once
      if (rst_i)
        state <= hold_req_i ? cpuctl_pkg::HOLD_HELD : cpuctl_pkg::HOLD_RUN;
      else
        state <= next_state;
      drive_q <= !rst_i && state == cpuctl_pkg::HOLD_HELD && !hold_req_i && pending_i;
    end
  end

  assign bus_hold_ack_o = state == cpuctl_pkg::HOLD_HELD;
  assign drive_pending_o = drive_q;
endmodule : cpuctl_hold

`default_nettype wire

// *** cpuctl_top.sv ***
// Processor control pins: hold, internal error, numeric error, warm init, irq.
// Assumes all inputs synchronous to clk_i and a classic Wishbone master.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`default_nettype none

module cpuctl_top
#(
  parameter int BIST_LEN = cpuctl_pkg::BIST_CYCLES,
  parameter int CMP_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic bus_hold_request_i,
  input wire logic bus_busy_i,
  input wire logic bus_lock_i,
  input wire logic cycle_pending_i,
  output logic bus_hold_ack_o,
  output logic bus_float_o,
  output logic drive_pending_o,
  input wire logic master_checker_select_n_i,
  input wire logic parity_error_i,
  input wire logic compare_valid_i,
  input wire logic [CMP_W-1:0] pin_sample_i,
  input wire logic [CMP_W-1:0] internal_value_i,
  output logic internal_error_out_n_o,
  output logic shutdown_o,
  input wire logic ignore_numeric_error_n_i,
  input wire logic dual_secondary_i,
  input wire logic exception_summary_flag_i,
  input wire logic fp_insn_valid_i,
  input wire logic fp_insn_nowait_i,
  output logic fp_execute_o,
  output logic fp_native_trap_o,
  input wire logic warm_init_in_i,
  output logic warm_restart_o,
  output logic bist_run_o,
  input wire logic maskable_irq_i,
  input wire logic insn_boundary_i,
  input wire logic inta_ready_i,
  input wire logic [7:0] inta_vector_i,
  output logic inta_cycle_o,
  output logic inta_lock_o,
  output logic [7:0] irq_vector_o,
  output logic irq_vector_valid_o,
  output logic local_int0_o
);
  localparam int BW = $clog2(BIST_LEN + 1);

  // Register bus and control state
  logic wb_ack;
  logic [31:0] rd_data;
  logic [31:0] status_word;
  logic [2:0] control;

  // Error detection
  logic checker_mode;
  logic internal_error_out_parity;
  logic [cpuctl_pkg::CHECK_DELAY-1:0] mismatch_pipe;
  logic shutdown;

  // Numeric error handling
  logic fp_halted;
  logic fp_execute;
  logic fp_native_trap;

  // Reset, warm init and self test
  logic rst_q;
  logic warm_q;
  logic warm_restart;
  logic [BW-1:0] bist_count;

  // Interrupt acknowledge sequencer
  cpuctl_pkg::cpuctl_irq_type irq_state;
  cpuctl_pkg::cpuctl_irq_type next_irq_state;
  logic [7:0] vector;
  logic vector_valid;
  logic local_int0;

  wire logic hold_ack;
  wire logic wb_req;
  wire logic wb_write;
  wire logic hit_control;
  wire logic hit_status;
  wire logic hit_vector;
  wire logic [31:0] next_rd_data;
  wire logic cmp_mismatch;
  wire logic ignore_active;
  wire logic fp_exc_pending;
  wire logic fp_live;
  wire logic fp_halt_now;
  wire logic fp_trap_now;
  wire logic fp_run_now;
  wire logic irq_enabled;
  wire logic irq_take;
  wire logic inta_active;
  wire logic vector_load;
  wire logic bist_start;
  wire logic bist_busy;
  wire logic warm_edge;

  // Register offset match, shared by every address decode
  function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] offset);
    reg_hit = adr == offset;
  endfunction : reg_hit

  // Hold arbitration keeps running through reset
  cpuctl_hold u_hold
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .hold_req_i(bus_hold_request_i),
    .busy_i(bus_busy_i),
    .locked_i(bus_lock_i),
    .pending_i(cycle_pending_i),
    .bus_hold_ack_o(hold_ack),
    .drive_pending_o(drive_pending_o)
  );

  // One wait state: ack follows the request by a clock and drops after one
  assign wb_req = wb_cyc_i && wb_stb_i;
  // Writes land only on the edge that samples ack high
  assign wb_write = wb_req && wb_we_i && wb_ack && wb_sel_i[0];
  assign hit_control = reg_hit(wb_adr_i, cpuctl_pkg::REG_CONTROL);
  assign hit_status = reg_hit(wb_adr_i, cpuctl_pkg::REG_STATUS);
  assign hit_vector = reg_hit(wb_adr_i, cpuctl_pkg::REG_VECTOR);
  assign next_rd_data = hit_control ? {29'h0, control} :
    hit_status ? status_word :
    hit_vector ? {24'h0, vector} : 32'h0;

  // Status is read-only; writes to it are dropped
  always_comb
  begin
    status_word = 32'h0;
    status_word[cpuctl_pkg::ST_HOLD] = hold_ack;
    status_word[cpuctl_pkg::ST_SHUTDOWN] = shutdown;
    status_word[cpuctl_pkg::ST_FP_HALT] = fp_halted;
    status_word[cpuctl_pkg::ST_BIST] = bist_busy;
    status_word[cpuctl_pkg::ST_CHECKER] = checker_mode;
    status_word[cpuctl_pkg::ST_IRQ_BUSY] = irq_state != cpuctl_pkg::IRQ_IDLE;
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (rst_i)
        wb_ack <= 1'b0;
      else
        wb_ack <= wb_req && !wb_ack;
      // Read data is captured in the request cycle and stands during ack
      if (wb_req && !wb_ack)
        rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (rst_i || warm_edge)
        control <= cpuctl_pkg::CONTROL_RESET;
      else if (wb_write && hit_control)
        control <= wb_dat_i[2:0];
    end
  end

  // Master or checker is sampled while reset is held and fixed after it
  assign cmp_mismatch = checker_mode && compare_valid_i
    && pin_sample_i != internal_value_i;

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (rst_i)
      begin
        checker_mode <= !master_checker_select_n_i;
        mismatch_pipe <= '0;
      end
      else
        mismatch_pipe <= {mismatch_pipe[cpuctl_pkg::CHECK_DELAY-2:0], cmp_mismatch};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (rst_i)
      begin
        internal_error_out_parity <= 1'b0;
        shutdown <= 1'b0;
      end
      else
      begin
        internal_error_out_parity <= parity_error_i;
        // A new fault outranks a warm init in the same clock
        if (internal_error_out_parity)
          shutdown <= 1'b1;
        else if (warm_edge)
          shutdown <= 1'b0;
      end
    end
  end

  // The secondary of a pair never honours the ignore pin
  assign ignore_active = !control[cpuctl_pkg::CTL_NATIVE] && !ignore_numeric_error_n_i
    && !dual_secondary_i;
  assign fp_exc_pending = exception_summary_flag_i && !ignore_active;
  assign fp_live = fp_insn_valid_i && !fp_halted && !shutdown;
  assign fp_trap_now = fp_live && control[cpuctl_pkg::CTL_NATIVE]
    && exception_summary_flag_i && !fp_insn_nowait_i;
  // Non-waiting control forms run in spite of a pending exception
  assign fp_halt_now = fp_live && !control[cpuctl_pkg::CTL_NATIVE] && fp_exc_pending && !fp_insn_nowait_i;
  assign fp_run_now = fp_live && !fp_trap_now && !fp_halt_now;

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (rst_i)
      begin
        fp_halted <= 1'b0;
        fp_execute <= 1'b0;
        fp_native_trap <= 1'b0;
      end
      else
      begin
        fp_execute <= fp_run_now;
        fp_native_trap <= fp_trap_now;
        // Halt wins over a wake-up in the same clock
        if (fp_halt_now)
          fp_halted <= 1'b1;
        else if (irq_take || warm_edge)
          fp_halted <= 1'b0;
      end
    end
  end

  // Self test only when warm init is high on the first clock out of reset
  assign bist_start = rst_q && !rst_i && warm_init_in_i;
  assign bist_busy = bist_count != '0;
  // Edge detector tracks the pin in reset, so no false edge follows it
  assign warm_edge = warm_init_in_i && !warm_q && !rst_i;

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      rst_q <= rst_i;
      warm_q <= warm_init_in_i;
      warm_restart <= warm_edge;
      if (rst_i)
        bist_count <= '0;
      else if (bist_start)
        bist_count <= BW'(BIST_LEN);
      else if (bist_busy)
        bist_count <= bist_count - 1'b1;
    end
  end

  // Legacy request path is closed while the pin serves the local controller
  assign irq_enabled = control[cpuctl_pkg::CTL_IEN] && !control[cpuctl_pkg::CTL_LAPIC];
  assign irq_take = irq_state == cpuctl_pkg::IRQ_IDLE && maskable_irq_i && irq_enabled
    && insn_boundary_i && !shutdown && !bist_busy;
  assign inta_active = irq_state == cpuctl_pkg::IRQ_ACK1 || irq_state == cpuctl_pkg::IRQ_ACK2;
  assign vector_load = irq_state == cpuctl_pkg::IRQ_ACK2 && inta_ready_i;

  always_comb
  begin
    next_irq_state = irq_state;
    case (irq_state)
      cpuctl_pkg::IRQ_IDLE:
        if (irq_take)
          next_irq_state = cpuctl_pkg::IRQ_ACK1;
      cpuctl_pkg::IRQ_ACK1:
        if (inta_ready_i)
          next_irq_state = cpuctl_pkg::IRQ_GAP;
      cpuctl_pkg::IRQ_GAP:
        next_irq_state = cpuctl_pkg::IRQ_ACK2;
      cpuctl_pkg::IRQ_ACK2:
        if (inta_ready_i)
          next_irq_state = cpuctl_pkg::IRQ_VEC;
      cpuctl_pkg::IRQ_VEC:
        next_irq_state = cpuctl_pkg::IRQ_IDLE;
      default:
        next_irq_state = cpuctl_pkg::IRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (rst_i)
      begin
        irq_state <= cpuctl_pkg::IRQ_IDLE;
        vector <= 8'h00;
        vector_valid <= 1'b0;
        local_int0 <= 1'b0;
      end
      else
      begin
        irq_state <= warm_edge ? cpuctl_pkg::IRQ_IDLE : next_irq_state;
        vector_valid <= vector_load;
        if (vector_load)
          vector <= inta_vector_i;
        local_int0 <= maskable_irq_i && control[cpuctl_pkg::CTL_LAPIC];
      end
    end
  end

  // Checker mode floats the bus as well as a granted hold
  assign bus_hold_ack_o = hold_ack;
  assign bus_float_o = hold_ack || checker_mode;
  assign wb_ack_o = wb_ack;
  assign wb_dat_o = rd_data;

  assign internal_error_out_n_o = !(internal_error_out_parity || mismatch_pipe[cpuctl_pkg::CHECK_DELAY-1]);
  assign shutdown_o = shutdown;

  assign fp_execute_o = fp_execute;
  assign fp_native_trap_o = fp_native_trap;

  assign warm_restart_o = warm_restart;
  assign bist_run_o = bist_busy;

  // Lock spans both acknowledges and the gap between them
  assign inta_cycle_o = inta_active;
  assign inta_lock_o = irq_state != cpuctl_pkg::IRQ_IDLE && irq_state != cpuctl_pkg::IRQ_VEC;
  assign irq_vector_o = vector;
  assign irq_vector_valid_o = vector_valid;
  assign local_int0_o = local_int0;
endmodule : cpuctl_top

`default_nettype wire

// *** cpuctl_sva.sv ***
// Port checker for cpuctl_top.
// Assumes ce_i held high.
`default_nettype none
module cpuctl_sva
#(
  parameter int CMP_W = 8
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_hold_request_i,
  input wire logic bus_lock_i,
  input wire logic bus_hold_ack_o,
  input wire logic bus_float_o,
  input wire logic parity_error_i,
  input wire logic internal_error_out_n_o,
  input wire logic master_checker_select_n_i,
  input wire logic compare_valid_i,
  input wire logic [CMP_W-1:0] pin_sample_i,
  input wire logic [CMP_W-1:0] internal_value_i,
  input wire logic inta_cycle_o,
  input wire logic inta_lock_o,
  input wire logic warm_init_in_i,
  input wire logic bist_run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_FLOAT: assert property (bus_hold_ack_o |-> bus_float_o) else $error("ack without float");
  AST_KEEP: assert property (bus_hold_ack_o && bus_hold_request_i |=> bus_hold_ack_o) else $error("ack lost");
  AST_LOCK: assert property (bus_lock_i && !bus_hold_ack_o |=> !bus_hold_ack_o) else $error("hold in lock");
  AST_DROP: assert property ($fell(bus_hold_request_i) |-> ##[0:2] !bus_hold_ack_o) else $error("ack stuck");
  AST_INTERNAL_ERROR_OUT: assert property (parity_error_i |-> ##[1:2] !internal_error_out_n_o) else $error("no internal_error_out");
  AST_CHECK: assert property (!master_checker_select_n_i && compare_valid_i && pin_sample_i != internal_value_i
    |-> ##2 !internal_error_out_n_o) else $error("no mismatch internal_error_out");
  AST_INTA: assert property (inta_cycle_o |-> inta_lock_o) else $error("inta unlocked");
  AST_BIST: assert property ($fell(rst_i) && warm_init_in_i |-> ##[0:2] bist_run_o) else $error("no bist");
  cover property ($rose(bus_hold_ack_o));
  cover property ($rose(inta_cycle_o));
  cover property ($rose(bist_run_o));
endmodule : cpuctl_sva
bind cpuctl_top cpuctl_sva #(.CMP_W(CMP_W)) chk (.*);
`default_nettype wire

// *** cpuctl_pic.sv ***
// Interrupt controller model.
// Assumes fire_i pulses one clock.
`default_nettype none
module cpuctl_pic
(
  input wire logic clk_i,
  input wire logic fire_i,
  input wire logic inta_cycle_i,
  output logic irq_o = 1'b0,
  output logic ready_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_i)
  begin
    irq_o <= fire_i || (irq_o && !inta_cycle_i);
    ready_o <= inta_cycle_i && !ready_o;
  end
endmodule : cpuctl_pic
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for cpuctl_top.
// Assumes the pic model answers acknowledges.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, fire = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, r;
  logic bus_hold_request_i = 1, bus_busy_i = 0, bus_lock_i = 0, cycle_pending_i = 1, bus_hold_ack_o, bus_float_o;
  logic drive_pending_o, master_checker_select_n_i = 1, parity_error_i = 0, compare_valid_i = 0, shutdown_o;
  logic [7:0] pin_sample_i = 8'h0, internal_value_i = 8'h0, inta_vector_i = 8'h0, irq_vector_o, vec;
  logic internal_error_out_n_o, ignore_numeric_error_n_i = 1, dual_secondary_i = 0, exception_summary_flag_i = 0;
  logic fp_insn_valid_i = 0, fp_insn_nowait_i = 0, fp_execute_o, fp_native_trap_o, warm_init_in_i = 1;
  logic warm_restart_o, bist_run_o, maskable_irq_i, insn_boundary_i = 1, inta_ready_i, inta_cycle_o;
  logic inta_lock_o, irq_vector_valid_o, local_int0_o;
  int mismatches = 0, checked = 0, seed = 32'h2ec2;
  cpuctl_top #(.BIST_LEN(4)) uut (.*);
  cpuctl_pic pic (.clk_i(clk_i), .fire_i(fire), .inta_cycle_i(inta_cycle_o), .irq_o(maskable_irq_i),
    .ready_o(inta_ready_i));
  always #50 clk_i = ~clk_i;
  task automatic chk(input logic ok);
    checked++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("CHECK FAILED %0t value differs", $time);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : bus
  task automatic summarize;
    if (mismatches == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  initial
  begin
    tick(5);
    rst_i <= 0;
    tick(3);
    chk(bus_hold_ack_o === 1'b1);
    chk(bist_run_o === 1'b1);
    {warm_init_in_i, bus_hold_request_i, bus_lock_i} <= 3'b001;
    tick(3);
    bus_hold_request_i <= 1;
    tick(4);
    chk(bus_hold_ack_o === 1'b0);
    bus_lock_i <= 0;
    tick(4);
    chk(bus_hold_ack_o === 1'b1);
    bus_hold_request_i <= 0;
    do @(posedge clk_i); while (bus_hold_ack_o);
    chk(drive_pending_o === 1'b1);
    bus(1, cpuctl_pkg::REG_CONTROL, 32'h2);
    bus(0, 4'hc, 32'h0);
    bus(0, cpuctl_pkg::REG_CONTROL, 32'h0);
    chk(q[2:0] === 3'h2);
    vec = 8'($random(seed));
    {inta_vector_i, fire} <= {vec, 1'b1};
    @(posedge clk_i);
    fire <= 0;
    do
    begin
      @(posedge clk_i);
      r = $random(seed);
      {ignore_numeric_error_n_i, exception_summary_flag_i, fp_insn_valid_i, fp_insn_nowait_i} <= r[3:0];
    end
    while (irq_vector_valid_o !== 1'b1);
    chk(irq_vector_o === vec);
    bus(1, cpuctl_pkg::REG_CONTROL, 32'h4);
    fire <= 1;
    @(posedge clk_i);
    fire <= 0;
    tick(2);
    chk(local_int0_o === 1'b1);
    chk(inta_cycle_o === 1'b0);
    parity_error_i <= 1;
    @(posedge clk_i);
    parity_error_i <= 0;
    tick(4);
    chk(shutdown_o === 1'b1);
    {rst_i, master_checker_select_n_i, ignore_numeric_error_n_i} <= 3'b101;
    {exception_summary_flag_i, fp_insn_valid_i, fp_insn_nowait_i} <= 3'b111;
    tick(5);
    rst_i <= 0;
    tick(2);
    chk(fp_execute_o === 1'b1);
    {ignore_numeric_error_n_i, fp_insn_nowait_i} <= 2'b00;
    tick(2);
    chk(fp_execute_o === 1'b1);
    bus(1, cpuctl_pkg::REG_CONTROL, 32'h1);
    tick(2);
    chk(fp_native_trap_o === 1'b1);
    chk(fp_execute_o === 1'b0);
    bus(1, cpuctl_pkg::REG_CONTROL, 32'h0);
    dual_secondary_i <= 1;
    tick(2);
    chk(fp_execute_o === 1'b0);
    bus(0, cpuctl_pkg::REG_STATUS, 32'h0);
    chk(q[cpuctl_pkg::ST_FP_HALT] === 1'b1);
    chk(q[cpuctl_pkg::ST_CHECKER] === 1'b1);
    chk(bus_float_o === 1'b1);
    warm_init_in_i <= 1;
    tick(2);
    chk(warm_restart_o === 1'b1);
    repeat (20)
    begin
      @(posedge clk_i);
      r = $random(seed);
      {compare_valid_i, pin_sample_i, internal_value_i} <= {1'b1, r[7:0], r[7:0] ^ {7'h0, r[8]}};
    end
    compare_valid_i <= 0;
    tick(4);
    {compare_valid_i, pin_sample_i, internal_value_i} <= {1'b1, 8'h01, 8'h00};
    @(posedge clk_i);
    compare_valid_i <= 0;
    tick(2);
    chk(internal_error_out_n_o === 1'b0);
    summarize();
  end
  initial
  begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule : tb
`default_nettype wire
